//--- bench/rdsenc_far_end.sv
// switches, strap network and pilot source around the encoder
`timescale 1ns/1ps
module rdsenc_far_end (
    // bench commands
    input wire logic [1:0] i_strap_sel,
    input wire logic i_ta_press,
    input wire logic i_lock_on,
    input wire logic i_pilot_on,
    // converter word seen by the strap diodes
    input wire logic [7:0] i_word,
    // device pins
    output logic o_strap,
    output logic o_ta_n,
    output logic o_lock_n,
    output logic o_pilot
);
    // open strap rests on the pull-up; a diode follows its bit low
    assign o_strap = (i_strap_sel == 2'h0) ? 1'b1 :
        (i_strap_sel == 2'h1) ? i_word[2] :
        (i_strap_sel == 2'h2) ? i_word[1] : 1'b0;
    assign o_ta_n = ~i_ta_press;
    assign o_lock_n = ~i_lock_on;
    // 19 khz square, unrelated in phase to the system clock
    initial begin
        o_pilot = 1'b0;
        forever begin
            #26316;
            o_pilot = i_pilot_on ? ~o_pilot : 1'b0;
        end
    end
endmodule

//--- bench/rdsenc_pin_ctrl_tb.sv
// self-checking bench of the encoder pin control
`timescale 1ns/1ps
module rdsenc_pin_ctrl_tb;
    logic clk, nrst, rpin_n, prog, cfg, sv, rdy, lamp_v, cap;
    logic [7:0] sd, last;
    logic [1:0] ssel;
    logic ta, lk, pon, strap, ta_n, lock_n, pilot;
    logic ready, crst_n, pll, tick, taf, lamp;
    logic [1:0] mode;
    logic [7:0] word;
    logic [7:0] sent[$], got[$];
    int bad_count, n_checks, k, n;

    rdsenc_pin_ctrl #(.POR_CYC(40), .BLINK_CYC(64), .FLASH_CYC(16)) u_dut (
        .i_sys_clk(clk), .i_nrst(nrst), .i_reset_pin_n(rpin_n),
        .i_pilot_lock_n(lock_n), .i_pilot(pilot),
        .i_traffic_announce_in_n(ta_n), .i_mode_strap(strap),
        .i_traffic_program_flag(prog), .i_cfg_rx_active(cfg),
        .i_sample_valid(sv), .i_sample_data(sd), .o_sample_ready(ready),
        .o_core_rst_n(crst_n), .o_comm_mode(mode), .o_pll_enable(pll),
        .o_subcarrier_tick(tick), .o_traffic_announce_flag(taf),
        .o_activity_lamp(lamp), .o_conv_word_out(word));
    rdsenc_far_end u_far (.i_strap_sel(ssel), .i_ta_press(ta),
        .i_lock_on(lk), .i_pilot_on(pon), .i_word(word), .o_strap(strap),
        .o_ta_n(ta_n), .o_lock_n(lock_n), .o_pilot(pilot));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cyc(int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    // bounded step until the watched level differs from v
    task automatic step_until(ref logic s, input logic v, output int c);
        c = 0;
        do begin
            cyc(1);
            c++;
        end while (s === v && c < 1000);
    endtask

    task automatic t_strap();
        for (int m = 0; m < 4; m++) begin
            ssel <= m[1:0];
            rpin_n <= 1'b0;
            cyc(60);
            check("core_rst_n held", crst_n, 0);
            rpin_n <= 1'b1;
            step_until(crst_n, 1'b0, k);
            check("comm_mode", mode, m);
        end
        ssel <= 2'h0;
        cyc(30);
        check("mode kept", mode, 3);
    endtask

    task automatic t_glitch();
        rpin_n <= 1'b0;
        cyc(10);
        rpin_n <= 1'b1;
        n = 0;
        repeat (100) begin
            cyc(1);
            if (crst_n !== 1'b1) n++;
        end
        check("glitch ignored", n, 0);
    endtask

    task automatic t_ta();
        prog <= 1'b1;
        ta <= 1'b1;
        cyc(8);
        check("ta flag on", taf, 1);
        ta <= 1'b0;
        cyc(8);
        check("ta flag off", taf, 0);
        prog <= 1'b0;
        ta <= 1'b1;
        cyc(8);
        check("ta no program", taf, 0);
        ta <= 1'b0;
    endtask

    task automatic t_pll();
        lk <= 1'b1;
        pon <= 1'b1;
        cyc(8);
        check("pll on", pll, 1);
        @(posedge pilot);
        step_until(tick, 1'b0, k);
        check("pilot locked tick", k < 8, 1);
        lk <= 1'b0;
        pon <= 1'b0;
        cyc(8);
        check("pll off", pll, 0);
        step_until(tick, 1'b0, k);
        cyc(1);
        step_until(tick, 1'b0, k);
        check("free tick gap", k == 437 || k == 438, 1);
    endtask

    task automatic t_lamp();
        step_until(lamp, lamp, k);
        lamp_v = lamp;
        step_until(lamp, lamp_v, k);
        check("blink half period", k >= 63 && k <= 65, 1);
        lamp_v = lamp;
        cfg <= 1'b1;
        cyc(1);
        cfg <= 1'b0;
        cyc(3);
        check("rx flash", lamp, !lamp_v);
    endtask

    task automatic t_fifo();
        last = word;
        cap = 1'b1;
        sv <= 1'b1;
        sd <= 8'h31;
        n = 0;
        rdy = 1'b1;
        for (k = 0; k < 30 && rdy; k++) begin
            @(negedge clk);
            rdy = ready;
            @(posedge clk);
            if (rdy) begin
                sent.push_back(sd);
                sd <= sd + 8'h11;
            end
        end
        sv <= 1'b0;
        check("fill refused", sent.size() >= 8 && !rdy, 1);
        for (k = 0; k < 2000 && got.size() < sent.size(); k++) cyc(1);
        check("drain count", got.size(), sent.size());
        foreach (sent[i])
            if (i < got.size()) check("conv word", got[i], sent[i]);
    endtask

    // sampled mid-cycle, where the converter word has settled
    always @(negedge clk) begin
        if (cap && word !== last) begin
            got.push_back(word);
            last <= word;
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        summarize();
    end

    initial begin
        {nrst, prog, cfg, sv, cap, ta, lk, pon} = '0;
        rpin_n = 1'b1;
        sd = 8'h00;
        ssel = 2'h0;
        bad_count = 0;
        n_checks = 0;
        cyc(12);
        check("core_rst_n por", crst_n, 0);
        check("word in reset", word, 0);
        nrst <= 1'b1;
        step_until(crst_n, 1'b0, k);
        // power-on hold of 40 plus two probe phases of 25
        check("por release", k, 40 + 2 * 25);
        t_strap();
        t_glitch();
        t_ta();
        t_pll();
        t_lamp();
        t_fifo();
        summarize();
    end
endmodule

//--- verilog/rdsenc_fifo.sv
// sample fifo with registered read data
`timescale 1ns/1ps
`include "rdsenc_params.svh"
module rdsenc_fifo #(
    parameter int unsigned WIDTH = `RDSENC_FIFO_W,
    parameter int unsigned DEPTH = `RDSENC_FIFO_D
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_flush,
    // fill side
    input wire logic i_wr_valid,
    input wire logic [WIDTH-1:0] i_wr_data,
    output logic o_wr_ready,
    // drain side
    output logic o_rd_valid,
    output logic [WIDTH-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic [WIDTH-1:0] rdata_reg, rdata_next;
    logic push, pop;

    assign o_wr_ready = (cnt_reg != FULL) && !i_flush;
    assign o_rd_valid = (cnt_reg != '0) && !i_flush;
    assign push = i_wr_valid && o_wr_ready;
    assign pop = o_rd_valid && i_rd_ready;
    assign o_rd_data = rdata_reg;

    // depth is a power of two, so pointers wrap by themselves
    always_comb begin
        wptr_next = push ? AW'(wptr_reg + 1'b1) : wptr_reg;
        rptr_next = pop ? AW'(rptr_reg + 1'b1) : rptr_reg;
        cnt_next = (AW + 1)'(cnt_reg + push - pop);
        // bypass when the word written is the next to be read
        if (push && wptr_reg == rptr_next) begin
            rdata_next = i_wr_data;
        end else begin
            rdata_next = mem[rptr_next];
        end
        if (i_flush) begin
            wptr_next = '0;
            rptr_next = '0;
            cnt_next = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wptr_reg] <= i_wr_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            rdata_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
            rdata_reg <= rdata_next;
        end
    end
endmodule

//--- verilog/rdsenc_params.svh
// timing, layout and pattern constants of the encoder pin control
`ifndef RDSENC_PARAMS_SVH
`define RDSENC_PARAMS_SVH

`define RDSENC_CLK_HZ 25000000
`define RDSENC_CLK_MHZ (`RDSENC_CLK_HZ / 1000000)

// power-on reset hold, in microseconds
`define RDSENC_POR_US 1000
`define RDSENC_POR_CYC (`RDSENC_POR_US * `RDSENC_CLK_MHZ)
// least low time on the reset pin that counts, in nanoseconds
`define RDSENC_RSTF_NS 2000
`define RDSENC_RSTF_CYC ((`RDSENC_RSTF_NS * `RDSENC_CLK_MHZ + 999) / 1000)
// settle time of each strap drive pattern, in nanoseconds
`define RDSENC_STRAP_NS 1000
`define RDSENC_STRAP_CYC ((`RDSENC_STRAP_NS * `RDSENC_CLK_MHZ + 999) / 1000)
// lamp half period and receive flash, in milliseconds
`define RDSENC_BLINK_MS 500
`define RDSENC_BLINK_CYC (`RDSENC_BLINK_MS * (`RDSENC_CLK_HZ / 1000))
`define RDSENC_FLASH_MS 50
`define RDSENC_FLASH_CYC (`RDSENC_FLASH_MS * (`RDSENC_CLK_HZ / 1000))

// subcarrier and converter sample rates, in hertz
`define RDSENC_SC_HZ 57000
`define RDSENC_SMP_HZ 361000
`define RDSENC_ACC_W 25
`define RDSENC_CNT_W 24
`define RDSENC_GAP_W 10

`define RDSENC_FIFO_W 8
`define RDSENC_FIFO_D 8

// bit positions in the synchronised pin vector
`define RDSENC_PIN_RST 0
`define RDSENC_PIN_SYNC 1
`define RDSENC_PIN_PILOT 2
`define RDSENC_PIN_TA 3
`define RDSENC_PIN_STRAP 4
`define RDSENC_NPIN 5
`define RDSENC_PIN_IDLE 5'h1f

// converter word during reset and strap probing
`define RDSENC_PAT_IDLE 8'h00
`define RDSENC_PAT_A 8'h04
`define RDSENC_PAT_B 8'h02

`endif

//--- verilog/rdsenc_pin_ctrl.sv
// pin-level control of the data-subcarrier encoder
//
// Overview of operation
// - stay in reset while reset pin low
// - filter short low pulses on reset pin
// - internal reset pulse after supply comes up
// - pilot loop runs only with enable low
// - lock subcarrier phase to pilot tone
// - otherwise time subcarrier from internal clock
// - announce flag set when program flag and input low
// - lamp blinks about once per second
// - lamp also flashes on configuration receive
// - 8-bit converter word, bit 0 least significant
// - mode strap sampled only leaving reset
// - strap high or open selects mode 0
// - strap diode to bit 2 selects mode 1
// - strap diode to bit 1 selects mode 2
// - strap grounded selects mode 3
`timescale 1ns/1ps
`include "rdsenc_params.svh"
module rdsenc_pin_ctrl #(
    parameter int unsigned POR_CYC = `RDSENC_POR_CYC,
    parameter int unsigned BLINK_CYC = `RDSENC_BLINK_CYC,
    parameter int unsigned FLASH_CYC = `RDSENC_FLASH_CYC
) (
    // clock and supply reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // device pins
    input wire logic i_reset_pin_n,
    input wire logic i_pilot_lock_n,
    input wire logic i_pilot,
    input wire logic i_traffic_announce_in_n,
    input wire logic i_mode_strap,
    // encoder core side
    input wire logic i_traffic_program_flag,
    input wire logic i_cfg_rx_active,
    input wire logic i_sample_valid,
    input wire logic [7:0] i_sample_data,
    output logic o_sample_ready,
    // status and timing to core
    output logic o_core_rst_n,
    output logic [1:0] o_comm_mode,
    output logic o_pll_enable,
    output logic o_subcarrier_tick,
    output logic o_traffic_announce_flag,
    // pins driven out
    output logic o_activity_lamp,
    output logic [7:0] o_conv_word_out
);
    localparam int unsigned CW = `RDSENC_CNT_W;
    localparam int unsigned AW = `RDSENC_ACC_W;
    localparam logic [CW-1:0] POR_LAST = CW'(POR_CYC - 1);
    localparam logic [CW-1:0] STRAP_LAST = CW'(`RDSENC_STRAP_CYC - 1);
    localparam logic [CW-1:0] RSTF_LAST = CW'(`RDSENC_RSTF_CYC - 1);
    localparam logic [CW-1:0] BLINK_LAST = CW'(BLINK_CYC - 1);
    localparam logic [CW-1:0] FLASH_LAST = CW'(FLASH_CYC - 1);
    localparam logic [AW-1:0] ACC_MOD = AW'(`RDSENC_CLK_HZ);
    localparam logic [AW-1:0] SC_INC = AW'(`RDSENC_SC_HZ);
    localparam logic [AW-1:0] SMP_INC = AW'(`RDSENC_SMP_HZ);

    // phase accumulator step; top bit flags a wrap
    function automatic logic [AW:0] nco_step(input logic [AW-1:0] acc,
                                             input logic [AW-1:0] inc);
        logic [AW:0] sum;
        sum = {1'b0, acc} + {1'b0, inc};
        if (sum >= {1'b0, ACC_MOD}) begin
            nco_step = {1'b1, AW'(sum - {1'b0, ACC_MOD})};
        end else begin
            nco_step = sum;
        end
    endfunction

    // strap level under pattern a, then under pattern b
    function automatic rdsenc_pkg::rdsenc_mode_t mode_of(input logic a,
                                                         input logic b);
        if (a && b) begin
            mode_of = rdsenc_pkg::MODE_SER_FAST_LO;
        end else if (a) begin
            mode_of = rdsenc_pkg::MODE_SER_FAST_HI;
        end else if (b) begin
            mode_of = rdsenc_pkg::MODE_SER_SLOW_LO;
        end else begin
            mode_of = rdsenc_pkg::MODE_TWO_WIRE;
        end
    endfunction

    // pin synchronisers: first stage feeds only the second
    logic [`RDSENC_NPIN-1:0] pin_raw, s1_reg, s2_reg, s3_reg;
    logic [`RDSENC_NPIN-1:0] qual_reg, qual_next;
    assign pin_raw = {i_mode_strap, i_traffic_announce_in_n, i_pilot,
                      i_pilot_lock_n, i_reset_pin_n};

    always_comb begin
        qual_next = qual_reg;
        for (int i = 0; i < `RDSENC_NPIN; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                qual_next[i] = s2_reg[i];
            end
        end
    end

    // pull-ups make every pin idle high
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s1_reg <= `RDSENC_PIN_IDLE;
            s2_reg <= `RDSENC_PIN_IDLE;
            s3_reg <= `RDSENC_PIN_IDLE;
            qual_reg <= `RDSENC_PIN_IDLE;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            qual_reg <= qual_next;
        end
    end

    // reset pin noise filter: a level counts once it has held
    logic rfilt_reg, rfilt_next;
    logic [CW-1:0] rfcnt_reg, rfcnt_next;
    always_comb begin
        rfilt_next = rfilt_reg;
        rfcnt_next = '0;
        if (qual_reg[`RDSENC_PIN_RST] != rfilt_reg) begin
            if (rfcnt_reg == RSTF_LAST) begin
                rfilt_next = qual_reg[`RDSENC_PIN_RST];
            end else begin
                rfcnt_next = CW'(rfcnt_reg + 1'b1);
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rfilt_reg <= 1'b1;
            rfcnt_reg <= '0;
        end else begin
            rfilt_reg <= rfilt_next;
            rfcnt_reg <= rfcnt_next;
        end
    end

    // reset sequencer with strap probing
    rdsenc_pkg::rdsenc_state_t st_reg, st_next;
    logic [CW-1:0] tmr_reg, tmr_next;
    logic strap_a_reg, strap_a_next;
    logic [1:0] mode_reg, mode_next;
    logic running;
    assign running = (st_reg == rdsenc_pkg::ST_RUN);

    always_comb begin
        st_next = st_reg;
        tmr_next = CW'(tmr_reg + 1'b1);
        strap_a_next = strap_a_reg;
        mode_next = mode_reg;
        unique case (st_reg)
            rdsenc_pkg::ST_POR: begin
                if (tmr_reg == POR_LAST) begin
                    st_next = rdsenc_pkg::ST_STRAP_A;
                    tmr_next = '0;
                end
            end
            rdsenc_pkg::ST_STRAP_A: begin
                if (tmr_reg == STRAP_LAST) begin
                    strap_a_next = qual_reg[`RDSENC_PIN_STRAP];
                    st_next = rdsenc_pkg::ST_STRAP_B;
                    tmr_next = '0;
                end
            end
            rdsenc_pkg::ST_STRAP_B: begin
                if (tmr_reg == STRAP_LAST) begin
                    mode_next = mode_of(strap_a_reg,
                                        qual_reg[`RDSENC_PIN_STRAP]);
                    st_next = rdsenc_pkg::ST_RUN;
                    tmr_next = '0;
                end
            end
            rdsenc_pkg::ST_RUN: begin
                tmr_next = '0;
            end
        endcase
        // a filtered low on the pin restarts the whole sequence
        if (!rfilt_reg) begin
            st_next = rdsenc_pkg::ST_POR;
            tmr_next = '0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= rdsenc_pkg::ST_POR;
            tmr_reg <= '0;
            strap_a_reg <= 1'b1;
            mode_reg <= rdsenc_pkg::MODE_SER_FAST_LO;
        end else begin
            st_reg <= st_next;
            tmr_reg <= tmr_next;
            strap_a_reg <= strap_a_next;
            mode_reg <= mode_next;
        end
    end

    assign o_core_rst_n = running;
    assign o_comm_mode = mode_reg;

    // subcarrier and sample-rate timing
    logic [AW-1:0] sc_acc_reg, sc_acc_next, smp_acc_reg, smp_acc_next;
    logic sc_tick_reg, sc_tick_next, smp_tick_reg, smp_tick_next;
    logic pilot_d_reg, pll_reg, pll_next, ta_reg, ta_next;
    logic [AW:0] sc_step, smp_step;
    logic pilot_edge;
    assign pilot_edge = qual_reg[`RDSENC_PIN_PILOT] && !pilot_d_reg;
    assign sc_step = nco_step(sc_acc_reg, SC_INC);
    assign smp_step = nco_step(smp_acc_reg, SMP_INC);

    always_comb begin
        pll_next = running && !qual_reg[`RDSENC_PIN_SYNC];
        sc_acc_next = sc_step[AW-1:0];
        sc_tick_next = running && sc_step[AW];
        smp_acc_next = smp_step[AW-1:0];
        smp_tick_next = running && smp_step[AW];
        // a pilot rise realigns the subcarrier; every third tick lines up
        if (pll_reg && pilot_edge) begin
            sc_acc_next = '0;
            sc_tick_next = 1'b1;
        end
        // announce input is a plain low-active switch or gate
        ta_next = running && i_traffic_program_flag &&
                  !qual_reg[`RDSENC_PIN_TA];
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sc_acc_reg <= '0;
            smp_acc_reg <= '0;
            sc_tick_reg <= 1'b0;
            smp_tick_reg <= 1'b0;
            pilot_d_reg <= 1'b1;
            pll_reg <= 1'b0;
            ta_reg <= 1'b0;
        end else begin
            sc_acc_reg <= sc_acc_next;
            smp_acc_reg <= smp_acc_next;
            sc_tick_reg <= sc_tick_next;
            smp_tick_reg <= smp_tick_next;
            pilot_d_reg <= qual_reg[`RDSENC_PIN_PILOT];
            pll_reg <= pll_next;
            ta_reg <= ta_next;
        end
    end

    assign o_pll_enable = pll_reg;
    assign o_subcarrier_tick = sc_tick_reg;
    assign o_traffic_announce_flag = ta_reg;

    // activity lamp: slow blink, inverted while receive flash runs
    logic [CW-1:0] blink_cnt_reg, blink_cnt_next, flash_reg, flash_next;
    logic blink_reg, blink_next, lamp_reg, lamp_next;
    always_comb begin
        blink_next = blink_reg;
        blink_cnt_next = CW'(blink_cnt_reg + 1'b1);
        if (!running) begin
            blink_cnt_next = '0;
            blink_next = 1'b0;
        end else if (blink_cnt_reg == BLINK_LAST) begin
            blink_cnt_next = '0;
            blink_next = !blink_reg;
        end
        flash_next = (flash_reg != '0) ? CW'(flash_reg - 1'b1) : '0;
        if (running && i_cfg_rx_active) begin
            flash_next = FLASH_LAST;
        end
        lamp_next = blink_reg ^ (flash_reg != '0);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
            flash_reg <= '0;
            lamp_reg <= 1'b0;
        end else begin
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
            flash_reg <= flash_next;
            lamp_reg <= lamp_next;
        end
    end

    assign o_activity_lamp = lamp_reg;

    // sample buffer drained at the converter rate
    logic fifo_valid, pop;
    logic [7:0] fifo_data, conv_reg, conv_next;
    assign pop = running && smp_tick_reg && fifo_valid;

    rdsenc_fifo #(
        .WIDTH(`RDSENC_FIFO_W),
        .DEPTH(`RDSENC_FIFO_D)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_flush(!running),
        .i_wr_valid(i_sample_valid),
        .i_wr_data(i_sample_data),
        .o_wr_ready(o_sample_ready),
        .o_rd_valid(fifo_valid),
        .o_rd_data(fifo_data),
        .i_rd_ready(running && smp_tick_reg)
    );

    // underrun holds the last word rather than dropping to zero
    always_comb begin
        conv_next = conv_reg;
        unique case (st_reg)
            rdsenc_pkg::ST_POR: conv_next = `RDSENC_PAT_IDLE;
            rdsenc_pkg::ST_STRAP_A: conv_next = `RDSENC_PAT_A;
            rdsenc_pkg::ST_STRAP_B: conv_next = `RDSENC_PAT_B;
            rdsenc_pkg::ST_RUN: begin
                if (pop) begin
                    conv_next = fifo_data;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            conv_reg <= `RDSENC_PAT_IDLE;
        end else begin
            conv_reg <= conv_next;
        end
    end

    assign o_conv_word_out = conv_reg;

    // checks
    localparam int unsigned GAP_LO = `RDSENC_CLK_HZ / `RDSENC_SC_HZ - 1;
    logic [`RDSENC_GAP_W-1:0] gap_reg;
    logic gap_ok_reg;
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            gap_reg <= '0;
            gap_ok_reg <= 1'b0;
        end else begin
            gap_reg <= sc_tick_reg ? '0 : `RDSENC_GAP_W'(gap_reg + 1'b1);
            // gap only means something between two ticks of one free run
            gap_ok_reg <= running && !pll_reg && (gap_ok_reg || sc_tick_reg);
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    property p_held;
        !rfilt_reg |=> !o_core_rst_n [*2];
    endproperty
    a_held: assert property (p_held) else $error("core left reset");
    property p_filt;
        $fell(rfilt_reg) |-> !$past(qual_reg[`RDSENC_PIN_RST]) &&
            !$past(qual_reg[`RDSENC_PIN_RST], 2);
    endproperty
    a_filt: assert property (p_filt) else $error("glitch reset");
    property p_por;
        $rose(st_reg == rdsenc_pkg::ST_STRAP_A) |->
            $past(tmr_reg) == POR_LAST && $past(rfilt_reg);
    endproperty
    a_por: assert property (p_por) else $error("short por");
    property p_pll;
        $rose(o_pll_enable) |-> $past(!qual_reg[`RDSENC_PIN_SYNC]) &&
            $past(running);
    endproperty
    a_pll: assert property (p_pll) else $error("pll on wrongly");
    property p_lock;
        (pll_reg && pilot_edge) |=> sc_tick_reg && sc_acc_reg == '0;
    endproperty
    a_lock: assert property (p_lock) else $error("no pilot lock");
    property p_free;
        (sc_tick_reg && gap_ok_reg) |->
            gap_reg == GAP_LO || gap_reg == GAP_LO + 1;
    endproperty
    a_free: assert property (p_free) else $error("free tick gap");
    property p_ta;
        (running && i_traffic_program_flag && !qual_reg[`RDSENC_PIN_TA] &&
         st_next == rdsenc_pkg::ST_RUN) |=> o_traffic_announce_flag;
    endproperty
    a_ta: assert property (p_ta) else $error("announce missed");
    property p_blink;
        (running && $changed(blink_reg)) |-> $past(blink_cnt_reg) == BLINK_LAST;
    endproperty
    a_blink: assert property (p_blink) else $error("blink rate");
    property p_flash;
        // lamp trails the blink register by one cycle
        (running && i_cfg_rx_active) |=> ##1
            o_activity_lamp != $past(blink_reg);
    endproperty
    a_flash: assert property (p_flash) else $error("no rx flash");
    property p_conv;
        pop && rfilt_reg |=> o_conv_word_out == $past(fifo_data);
    endproperty
    a_conv: assert property (p_conv) else $error("word lost");
    property p_mode;
        $changed(o_comm_mode) |-> $past(st_reg) == rdsenc_pkg::ST_STRAP_B;
    endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
    property p_mode0;
        (st_reg == rdsenc_pkg::ST_STRAP_B && tmr_reg == STRAP_LAST &&
         rfilt_reg && strap_a_reg && qual_reg[`RDSENC_PIN_STRAP]) |=>
            o_comm_mode == rdsenc_pkg::MODE_SER_FAST_LO;
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0");
    property p_mode3;
        (st_reg == rdsenc_pkg::ST_STRAP_B && tmr_reg == STRAP_LAST &&
         rfilt_reg && !strap_a_reg && !qual_reg[`RDSENC_PIN_STRAP]) |=>
            o_comm_mode == rdsenc_pkg::MODE_TWO_WIRE;
    endproperty
    a_mode3: assert property (p_mode3) else $error("mode 3");
    property p_probe;
        (st_reg == rdsenc_pkg::ST_STRAP_A && $past(st_reg) == st_reg) |->
            o_conv_word_out == `RDSENC_PAT_A;
    endproperty
    a_probe: assert property (p_probe) else $error("probe word");
    property p_sync;
        $changed(qual_reg) |-> $past(s2_reg != qual_reg || s3_reg != qual_reg);
    endproperty
    a_sync: assert property (p_sync) else $error("unsynced pin");

    c_run: cover property ($rose(running));
    c_two_wire: cover property ($rose(running) && o_comm_mode == 2'h3);
    c_lock: cover property (pll_reg && pilot_edge);
    c_full: cover property (running && !o_sample_ready);
endmodule

//--- verilog/rdsenc_pkg.sv
// types shared by the encoder pin control
package rdsenc_pkg;
    typedef enum logic [3:0] {
        ST_POR = 4'h1,
        ST_STRAP_A = 4'h2,
        ST_STRAP_B = 4'h4,
        ST_RUN = 4'h8
    } rdsenc_state_t;

    typedef enum logic [1:0] {
        MODE_SER_FAST_LO = 2'h0,
        MODE_SER_FAST_HI = 2'h1,
        MODE_SER_SLOW_LO = 2'h2,
        MODE_TWO_WIRE = 2'h3
    } rdsenc_mode_t;
endpackage
